// *** src/ssc_pkg.sv ***
package ssc_pkg;
    localparam int ADDR_W = 15;
    localparam logic [14:0] ADDR_SYSREF_CTRL = 15'h0120;
    localparam logic [14:0] ADDR_EVENT_COUNT = 15'h012a;
    localparam logic [14:0] ADDR_SYNC_MODE = 15'h01ff;
    localparam logic [14:0] ADDR_APP_MODE = 15'h0200;
    localparam logic [14:0] ADDR_DECIM = 15'h0201;
    localparam int CTRL_CNT_CLR_BIT = 6;
    localparam int CTRL_CAP_LO = 1;
    localparam int CTRL_CAP_HI = 2;
    localparam int SYNC_MODE_BIT = 0;
    localparam int Q_IGNORE_BIT = 5;
    localparam logic [7:0] SYNC_MODE_MASK = 8'h01;
    localparam logic [7:0] APP_MODE_MASK = 8'hef;
    localparam logic [7:0] DECIM_MASK = 8'h0f;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam logic [3:0] APP_FULL_BW = 4'h0;
    localparam logic [3:0] APP_ONE_PATH = 4'h1;
    localparam logic [3:0] APP_TWO_PATH = 4'h2;
    localparam logic [3:0] APP_FOUR_PATH = 4'h3;
    localparam logic [3:0] DECIM_BY_1 = 4'h0;
    localparam logic [3:0] DECIM_BY_2 = 4'h1;
endpackage : ssc_pkg

// *** src/ssc_regs.sv ***
// Function
// - Eight-bit count of captured SYSREF events, readable
// - Control bit 6 at 0x120 clears count
// - Count wraps from 255 to zero
// - Mode 0: SYSREF resets all clock dividers
// - Mode 0: divider phase change drops link
// - Mode 1: dividers, link, monitor left alone
// - Mode 1: tag coincident sample in output word
// - Bit 5 selects real-only output
// - Application mode selects path set
// - Decimation code 0 bypasses, 1 halves
module ssc_regs
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // Register port
    input wire logic REG_WR,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // SYSREF capture and divider status, from the sample path
    input wire logic SYSREF_CAPTURED,
    input wire logic DIVIDER_PHASE_OFF,
    // Controls to the converter path
    output logic DIVIDER_RESET,
    output logic LINK_DOWN,
    output logic SAMPLE_TAG,
    output logic REAL_ONLY,
    output logic [3:0] PATH_ENABLE,
    output logic DOWNCONVERTERS_BYPASSED,
    output logic DECIMATE_BY_TWO,
    output logic [3:0] DECIMATION_CODE
);
    logic [2:0] cap_sync;
    logic [2:0] phase_sync;
    logic [7:0] sysref_ctrl;
    logic [7:0] event_count;
    logic [7:0] sync_mode_select;
    logic [7:0] application_mode;
    logic [7:0] decimation_ratio_select;
    logic [7:0] next_sysref_ctrl;
    logic [7:0] next_event_count;
    logic [7:0] next_sync_mode_select;
    logic [7:0] next_application_mode;
    logic [7:0] next_decimation_ratio_select;
    logic cap_event;
    logic cap_seen;
    logic next_cap_seen;
    logic [7:0] next_rdata;
    logic next_div_reset;
    logic next_link_down;
    logic next_tag;
    logic next_real_only;
    logic [3:0] next_path_enable;
    logic [3:0] next_decim_code;
    logic next_bypassed;
    logic next_by_two;

    function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
        wr_hit = REG_WR && (REG_ADDR == a);
    endfunction : wr_hit

    // One enable per path: first, second, third, fourth downconverter
    function automatic logic [3:0] path_set(input logic [3:0] mode);
        case (mode)
            APP_FULL_BW: path_set = 4'h0;
            APP_ONE_PATH: path_set = 4'h1;
            APP_TWO_PATH: path_set = 4'h3;
            APP_FOUR_PATH: path_set = 4'hf;
            default: path_set = 4'h0;
        endcase
    endfunction : path_set

    // Three-stage sync; event counted once stages two and three agree
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            cap_sync <= 3'h0;
            phase_sync <= 3'h0;
        end else begin
            cap_sync <= {cap_sync[1:0], SYSREF_CAPTURED};
            phase_sync <= {phase_sync[1:0], DIVIDER_PHASE_OFF};
        end
    end

    // Capture edge and running event count
    always_comb begin
        next_cap_seen = cap_seen;
        next_event_count = event_count;
        if (cap_sync[2] == cap_sync[1]) begin
            next_cap_seen = cap_sync[2];
        end
        cap_event = (cap_sync[2] == cap_sync[1]) && cap_sync[2] && !cap_seen;
        if (sysref_ctrl[CTRL_CNT_CLR_BIT]) begin
            next_event_count = RESET_VALUE;
        end else if (cap_event) begin
            next_event_count = event_count + 8'h01;
        end
    end

    // Register writes; reserved bits are masked off, except in SYSREF control, which takes all eight bits
    always_comb begin
        next_sysref_ctrl = sysref_ctrl;
        next_sync_mode_select = sync_mode_select;
        next_application_mode = application_mode;
        next_decimation_ratio_select = decimation_ratio_select;
        if (wr_hit(ADDR_SYSREF_CTRL)) begin
            next_sysref_ctrl = REG_WDATA;
        end
        if (wr_hit(ADDR_SYNC_MODE)) begin
            next_sync_mode_select = REG_WDATA & SYNC_MODE_MASK;
        end
        if (wr_hit(ADDR_APP_MODE)) begin
            next_application_mode = REG_WDATA & APP_MODE_MASK;
        end
        if (wr_hit(ADDR_DECIM)) begin
            next_decimation_ratio_select = REG_WDATA & DECIM_MASK;
        end
    end

    // Link and divider actions per sync mode
    always_comb begin
        next_div_reset = 1'b0;
        next_link_down = LINK_DOWN;
        next_tag = 1'b0;
        // A drop seen in the same cycle wins over the clear by software
        if (wr_hit(ADDR_SYNC_MODE)) begin
            next_link_down = 1'b0;
        end
        if (sync_mode_select[SYNC_MODE_BIT]) begin
            next_tag = cap_event;
        end else begin
            next_div_reset = cap_event;
            if (cap_event && phase_sync[2] && phase_sync[1]) begin
                next_link_down = 1'b1;
            end
        end
    end

    always_comb begin
        case (REG_ADDR)
            ADDR_SYSREF_CTRL: next_rdata = sysref_ctrl;
            ADDR_EVENT_COUNT: next_rdata = event_count;
            ADDR_SYNC_MODE: next_rdata = sync_mode_select;
            ADDR_APP_MODE: next_rdata = application_mode;
            ADDR_DECIM: next_rdata = decimation_ratio_select;
            default: next_rdata = RESET_VALUE;
        endcase
    end

    // Register file
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            sysref_ctrl <= RESET_VALUE;
            sync_mode_select <= RESET_VALUE;
            application_mode <= RESET_VALUE;
            decimation_ratio_select <= RESET_VALUE;
        end else begin
            sysref_ctrl <= next_sysref_ctrl;
            sync_mode_select <= next_sync_mode_select;
            application_mode <= next_application_mode;
            decimation_ratio_select <= next_decimation_ratio_select;
        end
    end

    // Event counter and capture edge state
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            event_count <= RESET_VALUE;
            cap_seen <= 1'b0;
        end else begin
            event_count <= next_event_count;
            cap_seen <= next_cap_seen;
        end
    end

    // Divider, link and tag actions
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            DIVIDER_RESET <= 1'b0;
            LINK_DOWN <= 1'b0;
            SAMPLE_TAG <= 1'b0;
        end else begin
            DIVIDER_RESET <= next_div_reset;
            LINK_DOWN <= next_link_down;
            SAMPLE_TAG <= next_tag;
        end
    end

    // Read data
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            REG_RDATA <= RESET_VALUE;
        end else begin
            REG_RDATA <= next_rdata;
        end
    end

    // Datapath configuration, registered from the next register values
    always_comb begin
        next_real_only = next_application_mode[Q_IGNORE_BIT];
        next_path_enable = path_set(next_application_mode[3:0]);
        next_decim_code = next_decimation_ratio_select[3:0];
        next_bypassed = next_decim_code == DECIM_BY_1;
        next_by_two = next_decim_code == DECIM_BY_2;
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            REAL_ONLY <= 1'b0;
            PATH_ENABLE <= '0;
            DECIMATION_CODE <= DECIM_BY_1;
            DOWNCONVERTERS_BYPASSED <= 1'b1;
            DECIMATE_BY_TWO <= 1'b0;
        end else begin
            REAL_ONLY <= next_real_only;
            PATH_ENABLE <= next_path_enable;
            DECIMATION_CODE <= next_decim_code;
            DOWNCONVERTERS_BYPASSED <= next_bypassed;
            DECIMATE_BY_TWO <= next_by_two;
        end
    end
endmodule : ssc_regs

// *** verification/ssc_regs_monitor.sv ***
module ssc_regs_monitor
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // Register port
    input wire logic REG_WR,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    // Converter controls
    input wire logic DIVIDER_RESET,
    input wire logic LINK_DOWN,
    input wire logic SAMPLE_TAG,
    input wire logic REAL_ONLY,
    input wire logic [3:0] PATH_ENABLE,
    input wire logic DOWNCONVERTERS_BYPASSED,
    input wire logic DECIMATE_BY_TWO,
    input wire logic [3:0] DECIMATION_CODE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    property p_byp; DOWNCONVERTERS_BYPASSED == (DECIMATION_CODE == 4'h0);
    endproperty
    a_byp: assert property (p_byp) else $error("bypass bad");
    property p_by2; DECIMATE_BY_TWO == (DECIMATION_CODE == 4'h1); endproperty
    a_by2: assert property (p_by2) else $error("halve bad");
    property p_dec; REG_WR && REG_ADDR == ADDR_DECIM
        |=> DECIMATION_CODE == $past(REG_WDATA[3:0]); endproperty
    a_dec: assert property (p_dec) else $error("ratio bad");
    property p_ro; REG_WR && REG_ADDR == ADDR_APP_MODE
        |=> REAL_ONLY == $past(REG_WDATA[5]); endproperty
    a_ro: assert property (p_ro) else $error("real bad");
    property p_pe; REG_WR && REG_ADDR == ADDR_APP_MODE &&
        REG_WDATA[3:0] == 4'h3 |=> PATH_ENABLE == 4'hf; endproperty
    a_pe: assert property (p_pe) else $error("paths bad");
    property p_un; REG_ADDR == 15'h7fff |=> REG_RDATA == 8'h00; endproperty
    a_un: assert property (p_un) else $error("unmapped bad");
    property p_one; DIVIDER_RESET |=> !DIVIDER_RESET; endproperty
    a_one: assert property (p_one) else $error("reset pulse bad");
    property p_ex; !(DIVIDER_RESET && SAMPLE_TAG); endproperty
    a_ex: assert property (p_ex) else $error("mode mix");
    property p_ldc; $fell(LINK_DOWN) |->
        $past(REG_WR) && $past(REG_ADDR) == ADDR_SYNC_MODE; endproperty
    a_ldc: assert property (p_ldc) else $error("link clear bad");
    c_dr: cover property (DIVIDER_RESET);
    c_st: cover property (SAMPLE_TAG);
    c_ld: cover property ($rose(LINK_DOWN));
endmodule : ssc_regs_monitor
bind ssc_regs ssc_regs_monitor u_mon (
    .SYS_CLK(SYS_CLK),
    .RESETN(RESETN),
    .REG_WR(REG_WR),
    .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA),
    .DIVIDER_RESET(DIVIDER_RESET),
    .LINK_DOWN(LINK_DOWN),
    .SAMPLE_TAG(SAMPLE_TAG),
    .REAL_ONLY(REAL_ONLY),
    .PATH_ENABLE(PATH_ENABLE),
    .DOWNCONVERTERS_BYPASSED(DOWNCONVERTERS_BYPASSED),
    .DECIMATE_BY_TWO(DECIMATE_BY_TWO),
    .DECIMATION_CODE(DECIMATION_CODE)
);

// *** verification/testbench.sv ***
module testbench import ssc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic SYS_CLK = 0, RESETN = 0, REG_WR = 0, SYSREF_CAPTURED = 0;
    logic DIVIDER_PHASE_OFF = 0, DIVIDER_RESET, LINK_DOWN, SAMPLE_TAG;
    logic REAL_ONLY, DOWNCONVERTERS_BYPASSED, DECIMATE_BY_TWO;
    logic [ADDR_W-1:0] REG_ADDR = '0;
    logic [7:0] REG_WDATA = '0, REG_RDATA;
    logic [3:0] PATH_ENABLE, DECIMATION_CODE;
    int n_errors = 0, check_count = 0;
    ssc_regs dut (
        .SYS_CLK(SYS_CLK),
        .RESETN(RESETN),
        .REG_WR(REG_WR),
        .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA),
        .SYSREF_CAPTURED(SYSREF_CAPTURED),
        .DIVIDER_PHASE_OFF(DIVIDER_PHASE_OFF),
        .DIVIDER_RESET(DIVIDER_RESET),
        .LINK_DOWN(LINK_DOWN),
        .SAMPLE_TAG(SAMPLE_TAG),
        .REAL_ONLY(REAL_ONLY),
        .PATH_ENABLE(PATH_ENABLE),
        .DOWNCONVERTERS_BYPASSED(DOWNCONVERTERS_BYPASSED),
        .DECIMATE_BY_TWO(DECIMATE_BY_TWO),
        .DECIMATION_CODE(DECIMATION_CODE)
    );
    initial forever #2.5 SYS_CLK = ~SYS_CLK;
    task end_of_test;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    task chk(logic [7:0] g, e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task w(logic [14:0] a, logic [7:0] d);
        @(posedge SYS_CLK) {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
        @(posedge SYS_CLK) REG_WR <= 1'b0;
    endtask : w
    task r(logic [14:0] a, logic [7:0] e);
        @(posedge SYS_CLK) REG_ADDR <= a;
        repeat (2) @(posedge SYS_CLK);
        #1 chk(REG_RDATA, e);
    endtask : r
    task pls(logic [7:0] edr, etg);
        logic [7:0] a, b;
        a = 8'h00;
        b = 8'h00;
        @(posedge SYS_CLK) SYSREF_CAPTURED <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            @(posedge SYS_CLK) SYSREF_CAPTURED <= (i < 5);
            #1 a += DIVIDER_RESET === 1'b1;
            b += SAMPLE_TAG === 1'b1;
        end
        chk(a, edr);
        chk(b, etg);
    endtask : pls
    task t_regs;
        logic [3:0] pt [4];
        pt = '{4'h0, 4'h1, 4'h3, 4'hf};
        r(ADDR_APP_MODE, 8'h00);
        chk(DOWNCONVERTERS_BYPASSED, 8'h01);
        for (int m = 0; m < 4; m++) begin
            w(ADDR_APP_MODE, 8'(m));
            #1 chk(PATH_ENABLE, pt[m]);
        end
        w(ADDR_APP_MODE, 8'hff);
        r(ADDR_APP_MODE, 8'hef);
        chk(REAL_ONLY, 8'h01);
        w(ADDR_DECIM, 8'hf1);
        r(ADDR_DECIM, 8'h01);
        chk(DECIMATE_BY_TWO, 8'h01);
        w(ADDR_SYNC_MODE, 8'hff);
        r(ADDR_SYNC_MODE, 8'h01);
        w(ADDR_EVENT_COUNT, 8'h55);
        r(ADDR_EVENT_COUNT, 8'h00);
        r(15'h7fff, 8'h00);
    endtask : t_regs
    task t_cap;
        pls(8'h00, 8'h01);
        r(ADDR_EVENT_COUNT, 8'h01);
        w(ADDR_SYNC_MODE, 8'h00);
        @(posedge SYS_CLK) DIVIDER_PHASE_OFF <= 1'b1;
        pls(8'h01, 8'h00);
        chk(LINK_DOWN, 8'h01);
        w(ADDR_SYNC_MODE, 8'h00);
        @(posedge SYS_CLK) DIVIDER_PHASE_OFF <= 1'b0;
        pls(8'h01, 8'h00);
        chk(LINK_DOWN, 8'h00);
        repeat (252) pls(8'h01, 8'h00);
        r(ADDR_EVENT_COUNT, 8'hff);
        pls(8'h01, 8'h00);
        r(ADDR_EVENT_COUNT, 8'h00);
        pls(8'h01, 8'h00);
        w(ADDR_SYSREF_CTRL, 8'h40);
        r(ADDR_EVENT_COUNT, 8'h00);
    endtask : t_cap
    initial begin
        repeat (12) @(posedge SYS_CLK);
        RESETN <= 1'b1;
        t_regs;
        t_cap;
        end_of_test;
    end
    initial begin
        #100000;
        n_errors++;
        end_of_test;
    end
endmodule : testbench
